// File: rtl/spi_iso_channel.sv
`timescale 1ns/1ps
module spi_iso_channel
    import spi_iso_pkg::*;
#(
    parameter bit FILTER_EN = 1'b1,
    parameter logic [2:0] DIR_MASK = 3'h3,
    parameter int unsigned REFRESH_CYCLES = spi_iso_pkg::REFRESH_CYC,
    parameter int unsigned WDOG_CYCLES = spi_iso_pkg::WDOG_CYC
) (
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // internal free-running shuttle clock
    input wire logic shuttle_clk_i,
    // side 1 fast inputs from the master
    input wire logic master_side_clk_in_i,
    input wire logic master_side_data_out_in_i,
    input wire logic master_side_select_in_n_i,
    // side 2 fast input from the slave
    input wire logic slave_side_data_in_i,
    // side 1 fast output to the master
    output logic master_side_data_return_out_o,
    output logic master_side_data_return_out_oe_o,
    // side 2 fast outputs to the slave
    output logic slave_side_clk_out_o,
    output logic slave_side_data_out_o,
    output logic slave_side_select_out_n_o,
    output logic slave_side_oe_o,
    // slow channels; DIR_MASK bit high means side 1 to side 2
    input wire logic [2:0] slow_channel_input_s1_i,
    input wire logic [2:0] slow_channel_input_s2_i,
    output logic [2:0] slow_channel_output_s1_o,
    output logic [2:0] slow_channel_output_s2_o,
    output logic slow_channel_oe_o,
    // status
    output logic dc_mismatch_o
);
    import spi_iso_pkg::*;

    localparam logic [3:0] FILT_MASK = {1'b1, FILTER_EN, FILTER_EN, FILTER_EN};
    localparam logic [CNT_W-1:0] GLITCH_LAST = CNT_W'(GLITCH_CYC - 1);
    localparam logic [CNT_W-1:0] REFRESH_LAST = CNT_W'(REFRESH_CYCLES - 1);
    localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_CYCLES - 1);

    // ==========================================
    // fast paths
    logic [FAST_N-1:0] fast_in;
    logic [FAST_N-1:0] fast_out_r;

    // routing fixed: the slave sees master pins, the master sees the slave pin
    assign fast_in[FP_CLK] = master_side_clk_in_i;
    assign fast_in[FP_MOSI] = master_side_data_out_in_i;
    assign fast_in[FP_MISO] = slave_side_data_in_i;
    assign fast_in[FP_SEL] = master_side_select_in_n_i;

    genvar gi;
    generate
        for (gi = 0; gi < FAST_N; gi++) begin : g_fast
            logic [2:0] sync_r;
            logic [CNT_W-1:0] glitch_cnt_r;
            logic [CNT_W-1:0] idle_cnt_r;
            logic agreed;
            // only stages two and three are looked at
            assign agreed = (sync_r[1] == sync_r[2]) ? sync_r[1] : fast_out_r[gi];

            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    sync_r <= {3{FAST_RST[gi]}};
                end else begin
                    sync_r <= {sync_r[1:0], fast_in[gi]};
                end
            end

            // level follower only, no sampling on the spi clock, so every mode passes
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    glitch_cnt_r <= '0;
                    idle_cnt_r <= '0;
                    fast_out_r[gi] <= FAST_RST[gi];
                end else if (agreed != fast_out_r[gi]) begin
                    idle_cnt_r <= '0;
                    if (!FILT_MASK[gi] || glitch_cnt_r >= GLITCH_LAST) begin
                        fast_out_r[gi] <= agreed;
                        glitch_cnt_r <= '0;
                    end else begin
                        glitch_cnt_r <= glitch_cnt_r + 1'b1;
                    end
                end else begin
                    // a pulse cut short restarts the filter; unfiltered edges just pass
                    glitch_cnt_r <= '0;
                    if (idle_cnt_r >= REFRESH_LAST) begin
                        // refresh re-asserts the settled input level
                        idle_cnt_r <= '0;
                        if (sync_r[1] == sync_r[2]) begin
                            fast_out_r[gi] <= sync_r[2];
                        end
                    end else begin
                        idle_cnt_r <= idle_cnt_r + 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign slave_side_clk_out_o = fast_out_r[FP_CLK];
    assign slave_side_data_out_o = fast_out_r[FP_MOSI];
    assign slave_side_select_out_n_o = fast_out_r[FP_SEL];
    assign master_side_data_return_out_o = fast_out_r[FP_MISO];

    // ==========================================
    // link domain reset
    logic [1:0] link_rst_r;
    logic link_rst;
    always_ff @(posedge shuttle_clk_i) begin
        link_rst_r <= {link_rst_r[0], srst_i};
    end
    assign link_rst = link_rst_r[1];

    // ==========================================
    // inputs into the shuttle domain
    logic [2:0] s1_sync_r [3];
    logic [2:0] s2_sync_r [3];
    logic [2:0] s1_lvl_r;
    logic [2:0] s2_lvl_r;
    logic [FAST_N-1:0] fin_sync_r [3];
    logic [FAST_N-1:0] fout_sync_r [3];
    logic [FAST_N-1:0] fin_lvl_r;
    logic [FAST_N-1:0] fout_lvl_r;

    always_ff @(posedge shuttle_clk_i) begin
        if (link_rst) begin
            s1_sync_r <= '{default: '0};
            s2_sync_r <= '{default: '0};
            fin_sync_r <= '{default: FAST_RST};
            fout_sync_r <= '{default: FAST_RST};
        end else begin
            s1_sync_r <= '{slow_channel_input_s1_i, s1_sync_r[0], s1_sync_r[1]};
            s2_sync_r <= '{slow_channel_input_s2_i, s2_sync_r[0], s2_sync_r[1]};
            fin_sync_r <= '{fast_in, fin_sync_r[0], fin_sync_r[1]};
            fout_sync_r <= '{fast_out_r, fout_sync_r[0], fout_sync_r[1]};
        end
    end

    // a bit counts only once stages two and three agree
    always_ff @(posedge shuttle_clk_i) begin
        if (link_rst) begin
            s1_lvl_r <= '0;
            s2_lvl_r <= '0;
            fin_lvl_r <= FAST_RST;
            fout_lvl_r <= FAST_RST;
        end else begin
            for (int b = 0; b < 3; b++) begin
                if (s1_sync_r[1][b] == s1_sync_r[2][b]) s1_lvl_r[b] <= s1_sync_r[2][b];
                if (s2_sync_r[1][b] == s2_sync_r[2][b]) s2_lvl_r[b] <= s2_sync_r[2][b];
            end
            for (int f = 0; f < FAST_N; f++) begin
                if (fin_sync_r[1][f] == fin_sync_r[2][f]) fin_lvl_r[f] <= fin_sync_r[2][f];
                if (fout_sync_r[1][f] == fout_sync_r[2][f]) fout_lvl_r[f] <= fout_sync_r[2][f];
            end
        end
    end

    // ==========================================
    // ping-pong shuttle
    shuttle_phase_t phase_r;
    logic [2:0] pkt_slow_r;
    logic [FAST_N-1:0] pkt_fast_r;
    logic [2:0] slow_s1_r;
    logic [2:0] slow_s2_r;
    logic dc_mismatch_r;
    logic beat_r;

    always_ff @(posedge shuttle_clk_i) begin
        if (link_rst) begin
            phase_r <= PH_SIDE1;
            beat_r <= 1'b0;
        end else begin
            phase_r <= (phase_r == PH_SIDE1) ? PH_SIDE2 : PH_SIDE1;
            beat_r <= ~beat_r;
        end
    end

    // one snapshot per phase: close edges merge or split by a whole period
    always_ff @(posedge shuttle_clk_i) begin
        if (link_rst) begin
            pkt_slow_r <= '0;
            pkt_fast_r <= FAST_RST;
        end else begin
            case (phase_r)
                PH_SIDE1: begin
                    pkt_slow_r <= s1_lvl_r;
                    pkt_fast_r <= fin_lvl_r & ~(4'h1 << FP_MISO);
                end
                PH_SIDE2: begin
                    pkt_slow_r <= s2_lvl_r;
                    pkt_fast_r <= fin_lvl_r & (4'h1 << FP_MISO);
                end
                default: begin
                    pkt_slow_r <= pkt_slow_r;
                    pkt_fast_r <= pkt_fast_r;
                end
            endcase
        end
    end

    // packet built in the last phase is handled on the far side now
    always_ff @(posedge shuttle_clk_i) begin
        if (link_rst) begin
            slow_s1_r <= {3{SLOW_RST}};
            slow_s2_r <= {3{SLOW_RST}};
            dc_mismatch_r <= 1'b0;
        end else begin
            case (phase_r)
                PH_SIDE2: begin
                    // side 1 packet lands on side 2
                    slow_s2_r <= (pkt_slow_r & DIR_MASK) | (slow_s2_r & ~DIR_MASK);
                    dc_mismatch_r <= |((pkt_fast_r ^ fout_lvl_r) & ~(4'h1 << FP_MISO));
                end
                PH_SIDE1: begin
                    slow_s1_r <= (pkt_slow_r & ~DIR_MASK) | (slow_s1_r & DIR_MASK);
                    dc_mismatch_r <= |((pkt_fast_r ^ fout_lvl_r) & (4'h1 << FP_MISO));
                end
                default: begin
                    dc_mismatch_r <= dc_mismatch_r;
                end
            endcase
        end
    end

    assign slow_channel_output_s1_o = slow_s1_r;
    assign slow_channel_output_s2_o = slow_s2_r;
    assign dc_mismatch_o = dc_mismatch_r;

    // ==========================================
    // watchdog on shuttle activity
    logic [2:0] beat_sync_r;
    logic [CNT_W-1:0] wd_cnt_r;
    logic alive_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            beat_sync_r <= '0;
        end else begin
            beat_sync_r <= {beat_sync_r[1:0], beat_r};
        end
    end

    // a stopped shuttle clock cannot flag itself, so the system clock watches it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wd_cnt_r <= '0;
            alive_r <= 1'b1;
        end else if (beat_sync_r[1] != beat_sync_r[2]) begin
            wd_cnt_r <= '0;
            alive_r <= 1'b1;
        end else if (wd_cnt_r >= WDOG_LAST) begin
            alive_r <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
        end
    end

    // the data-return pin never floats on select; only a dead link releases it
    assign master_side_data_return_out_oe_o = alive_r;
    assign slave_side_oe_o = alive_r;
    assign slow_channel_oe_o = alive_r;

endmodule : spi_iso_channel

// File: rtl/spi_iso_pkg.sv
package spi_iso_pkg;
    // ==========================================
    // clocking
    localparam int unsigned SYS_PERIOD_PS = 4000;
    // ==========================================
    // fast path indices
    localparam int unsigned FAST_N = 4;
    localparam int unsigned FP_CLK = 0;
    localparam int unsigned FP_MOSI = 1;
    localparam int unsigned FP_MISO = 2;
    localparam int unsigned FP_SEL = 3;
    // ==========================================
    // times in their own units, cycle counts derived
    localparam int unsigned GLITCH_NS = 10;
    localparam int unsigned GLITCH_CYC = (GLITCH_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int unsigned REFRESH_NS = 1200;
    localparam int unsigned REFRESH_CYC = (REFRESH_NS * 1000) / SYS_PERIOD_PS;
    localparam int unsigned WDOG_NS = 5000;
    localparam int unsigned WDOG_CYC = (WDOG_NS * 1000) / SYS_PERIOD_PS;
    localparam int unsigned SLOW_LAT_MIN_NS = 100;
    localparam int unsigned SLOW_LAT_MAX_NS = 2600;
    // ==========================================
    // counter widths and reset values
    localparam int unsigned CNT_W = 12;
    localparam logic [3:0] FAST_RST = 4'h8;
    localparam logic SLOW_RST = 1'b0;
    // ==========================================
    // shuttle phase
    typedef enum logic [0:0] {
        PH_SIDE1 = 1'b0,
        PH_SIDE2 = 1'b1
    } shuttle_phase_t;
endpackage : spi_iso_pkg

// File: bench/spi_iso_channel_asserts.sv
`timescale 1ns/1ps
module spi_iso_channel_asserts #(
    parameter int unsigned WDOG_CYCLES = 1250
) (
    // clocks and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic shuttle_clk_i,
    // fast inputs
    input wire logic master_side_clk_in_i,
    input wire logic master_side_select_in_n_i,
    input wire logic slave_side_data_in_i,
    // outputs
    input wire logic master_side_data_return_out_o,
    input wire logic master_side_data_return_out_oe_o,
    input wire logic slave_side_clk_out_o,
    input wire logic slave_side_select_out_n_o,
    input wire logic slave_side_oe_o,
    input wire logic [2:0] slow_channel_output_s1_o,
    input wire logic [2:0] slow_channel_output_s2_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // ==========================================
    // cycles since the shuttle clock last moved
    logic shuttle_seen_r;
    int unsigned stall_cnt_r;
    always_ff @(posedge sys_clk_i) begin
        shuttle_seen_r <= shuttle_clk_i;
        if (srst_i || shuttle_seen_r != shuttle_clk_i) begin
            stall_cnt_r <= 0;
        end else if (stall_cnt_r < 4000) begin
            stall_cnt_r <= stall_cnt_r + 1;
        end
    end
    // ==========================================
    // properties
    clk_path_a: assert property ($stable(master_side_clk_in_i)[*8] |=>
        slave_side_clk_out_o == $past(master_side_clk_in_i)) else $error("clock path wrong");
    ret_path_a: assert property ($stable(slave_side_data_in_i)[*8] |=>
        master_side_data_return_out_o == $past(slave_side_data_in_i)) else $error("return wrong");
    sel_path_a: assert property ($stable(master_side_select_in_n_i)[*8] |=>
        slave_side_select_out_n_o == $past(master_side_select_in_n_i)) else $error("select wrong");
    clk_filter_a: assert property ($rose(slave_side_clk_out_o) |->
        $past(master_side_clk_in_i, 3) && $past(master_side_clk_in_i, 4)) else $error("clk glitch");
    sel_filter_a: assert property ($fell(slave_side_select_out_n_o) |->
        !$past(master_side_select_in_n_i, 3) && !$past(master_side_select_in_n_i, 4))
        else $error("select glitch passed");
    ret_oe_a: assert property ($fell(master_side_data_return_out_oe_o) |->
        stall_cnt_r >= WDOG_CYCLES - 24) else $error("return output released early");
    wdog_trip_a: assert property (stall_cnt_r == WDOG_CYCLES + 8 |->
        !slave_side_oe_o && !master_side_data_return_out_oe_o) else $error("watchdog idle");
    // bench runs channels 0 and 1 toward side 2, channel 2 toward side 1
    slow_dir_a: assert property ($stable(slow_channel_output_s2_o[2]) &&
        $stable(slow_channel_output_s1_o[1:0])) else $error("slow channel wrong way");
    slow_alt_a: assert property ($changed(slow_channel_output_s2_o) |->
        $stable(slow_channel_output_s1_o)) else $error("both sides updated together");
    cover property ($fell(slave_side_select_out_n_o));
    cover property ($fell(slave_side_oe_o));
    cover property ($changed(slow_channel_output_s2_o));
endmodule : spi_iso_channel_asserts

bind spi_iso_channel spi_iso_channel_asserts #(.WDOG_CYCLES(WDOG_CYCLES)) i_chk (
    .sys_clk_i,
    .srst_i,
    .shuttle_clk_i,
    .master_side_clk_in_i,
    .master_side_select_in_n_i,
    .slave_side_data_in_i,
    .master_side_data_return_out_o,
    .master_side_data_return_out_oe_o,
    .slave_side_clk_out_o,
    .slave_side_select_out_n_o,
    .slave_side_oe_o,
    .slow_channel_output_s1_o,
    .slow_channel_output_s2_o
);

// File: bench/spi_iso_slave_model.sv
`timescale 1ns/1ps
module spi_iso_slave_model (
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic sel_n_i,
    input wire logic [7:0] tx_i,
    output logic sdo_o,
    output logic [7:0] rx_o
);
    logic [7:0] sh_r;
    logic seen_r;
    initial begin
        sdo_o = 1'b0;
        rx_o = 8'h00;
        seen_r = 1'b0;
    end
    // ==========================================
    // outputs move only on clock or select edges, never a short pulse
    always @(negedge sel_n_i) begin
        sh_r = tx_i;
        sdo_o = sh_r[7];
        seen_r = 1'b0;
    end
    always @(posedge sclk_i) if (!sel_n_i) begin
        rx_o = {rx_o[6:0], sdi_i};
        seen_r = 1'b1;
    end
    // no shift before a first rising edge, so idle-high clocks work too
    always @(negedge sclk_i) if (!sel_n_i && seen_r) begin
        sh_r = {sh_r[6:0], 1'b0};
        sdo_o = sh_r[7];
    end
    // released line does not keep its last value
    always @(posedge sel_n_i) sdo_o = ~sdo_o;
endmodule : spi_iso_slave_model

// File: bench/tb_spi_iso_channel.sv
`timescale 1ns/1ps
module tb_spi_iso_channel;
    localparam int unsigned WDOG_T = 100;
    logic sys_clk = 1'b0, srst = 1'b1, sh_clk = 1'b0, sh_run = 1'b1;
    logic mclk = 1'b0, mdo = 1'b0, msel_n = 1'b1, sdi, ret, ret_oe, sclk, sdo, ssel_n, s_oe;
    logic slow_oe, dc_mm;
    logic [2:0] s1_in = 3'h0, s2_in = 3'h0, s1_out, s2_out;
    logic [7:0] tx_pat = 8'h00, rx;
    int n_mismatch = 0, cmp_count = 0, cycle_cnt = 0;
    always #2 sys_clk = ~sys_clk;
    initial begin
        #13;
        forever #40 if (sh_run) sh_clk = ~sh_clk;
    end
    spi_iso_channel #(.FILTER_EN(1'b1), .DIR_MASK(3'h3), .REFRESH_CYCLES(20),
        .WDOG_CYCLES(WDOG_T)) i_dut (.sys_clk_i(sys_clk), .srst_i(srst), .shuttle_clk_i(sh_clk),
        .master_side_clk_in_i(mclk), .master_side_data_out_in_i(mdo),
        .master_side_select_in_n_i(msel_n), .slave_side_data_in_i(sdi),
        .master_side_data_return_out_o(ret), .master_side_data_return_out_oe_o(ret_oe),
        .slave_side_clk_out_o(sclk), .slave_side_data_out_o(sdo),
        .slave_side_select_out_n_o(ssel_n), .slave_side_oe_o(s_oe),
        .slow_channel_input_s1_i(s1_in), .slow_channel_input_s2_i(s2_in),
        .slow_channel_output_s1_o(s1_out), .slow_channel_output_s2_o(s2_out),
        .slow_channel_oe_o(slow_oe), .dc_mismatch_o(dc_mm));
    spi_iso_slave_model i_slave (.sclk_i(sclk), .sdi_i(sdo), .sel_n_i(ssel_n), .tx_i(tx_pat),
        .sdo_o(sdi), .rx_o(rx));
    // ==========================================
    // shared tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_cyc
    task automatic complete_run;
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // ==========================================
    // scenarios
    task automatic spi_byte(input logic pol, input logic [7:0] tx);
        logic [7:0] got;
        got = 8'h00;
        @(posedge sys_clk);
        tx_pat = ~tx;
        mclk <= pol;
        wait_cyc(24);
        msel_n <= 1'b0;
        wait_cyc(24);
        for (int i = 7; i >= 0; i--) begin
            mdo <= tx[i];
            mclk <= 1'b0;
            wait_cyc(24);
            @(negedge sys_clk);
            got = {got[6:0], ret};
            @(posedge sys_clk);
            mclk <= 1'b1;
            wait_cyc(24);
        end
        mclk <= pol;
        wait_cyc(24);
        msel_n <= 1'b1;
        wait_cyc(24);
        check("rx", rx, tx);
        check("ret", got, ~tx);
        check("ret_oe", {7'h0, ret_oe}, 8'h01);
    endtask : spi_byte
    task automatic glitch;
        logic moved;
        moved = 1'b0;
        // settle the clock low first, so the pulse is a real 0-1-0 glitch
        mclk <= 1'b0;
        wait_cyc(24);
        msel_n <= 1'b0;
        mclk <= 1'b1;
        wait_cyc(2);
        msel_n <= 1'b1;
        mclk <= 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            if (ssel_n !== 1'b1 || sclk !== 1'b0) moved = 1'b1;
        end
        check("glitch", {7'h0, moved}, 8'h00);
    endtask : glitch
    task automatic slow_xfer(input logic [2:0] v);
        logic [2:0] o1, o2;
        int t;
        @(posedge sys_clk);
        o1 = s1_out;
        o2 = s2_out;
        t = 0;
        s1_in <= v;
        s2_in <= v;
        do begin @(negedge sys_clk); t++; end while (s2_out === o2 && t < 800);
        check("s2_out", {5'h0, s2_out}, {5'h0, o2[2], v[1:0]});
        check("lat", {7'h0, t >= 25 && t <= 650}, 8'h01);
        while (s1_out === o1 && t < 800) begin @(negedge sys_clk); t++; end
        check("s1_out", {5'h0, s1_out}, {5'h0, v[2], o1[1:0]});
    endtask : slow_xfer
    task automatic wdog;
        sh_run = 1'b0;
        wait_cyc(WDOG_T + 60);
        @(negedge sys_clk);
        check("oe_off", {5'h0, s_oe, slow_oe, ret_oe}, 8'h00);
        sh_run = 1'b1;
        wait_cyc(200);
        @(negedge sys_clk);
        check("oe_on", {5'h0, s_oe, slow_oe, ret_oe}, 8'h07);
    endtask : wdog
    // ==========================================
    // main sequence; reset outlasts three shuttle edges
    always @(posedge sys_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 8000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        wait_cyc(64);
        srst <= 1'b0;
        @(negedge sys_clk);
        check("rst", {4'h0, ssel_n, s_oe, slow_oe, dc_mm}, 8'h0e);
        spi_byte(1'b0, 8'ha5);
        spi_byte(1'b1, 8'h3c);
        glitch();
        slow_xfer(3'h7);
        slow_xfer(3'h0);
        check("dc", {7'h0, dc_mm}, 8'h00);
        wdog();
        complete_run();
    end
endmodule : tb_spi_iso_channel
